/* inc/ssp_regs.svh */
// Register offsets, field positions, reset values and counts of the serial port.
// Function
// - All-ones mask equals unmasked network receive
// - Masked slot: no copy, flags, interrupt
// - Sample data pin only in enabled slots
// - Receive frame starts at frame sync rise
// - Sample data on bit clock falling edge
// - Word clock copies shift word if enabled
// - Enabled word sets ready; interrupt if enabled
// - Reading receive data clears pending interrupt
// - Power-on reset clears controls and enable, mask all ones
// - Enable clear resets status, keeps controls
// - Internal bit clock held low throughout reset
// - Word clock counts 8/10/12/16 bits
// - Frame counter marks frame on sync pins
// - Bit clock external or divided, on pins
// - Transmit changes on rising, polarity inverts
// - Receive polarity bit moves capture edge
// - Transmit sync invert and early timing
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// Byte offsets on the register bus.
`define SSP_OFS_CTRL2    8'h00
`define SSP_OFS_CSR      8'h04
`define SSP_OFS_RXCTRL   8'h08
`define SSP_OFS_RXMASK   8'h0c
`define SSP_OFS_RXDATA   8'h10
`define SSP_OFS_TXDATA   8'h14

// Status bit positions in the low half of the control and status register.
`define SSP_ST_READY     0
`define SSP_ST_OVERRUN   1
// The control half of the control and status register starts here.
`define SSP_CSR_CTL_LSB  16

// Reset values.
`define SSP_RST_CTRL     16'h0000
`define SSP_RST_CSRCTL   16'h0000
`define SSP_RST_RXCTRL   16'h0000
`define SSP_RST_MASK     32'hffffffff

// Word lengths selected by the word length field.
`define SSP_WL_0         5'h08
`define SSP_WL_1         5'h0a
`define SSP_WL_2         5'h0c
`define SSP_WL_3         5'h10

`endif

/* inc/ssp_pkg.sv */
// Types shared by the serial port design.
package ssp_pkg;

  // Port control register two, low 16 bits.
  typedef struct packed {
    logic [6:0] rsvd;
    logic       fs_internal;
    logic       clk_internal;
    logic       tx_frame_sync_length;
    logic       tx_early_frame_sync;
    logic       tx_frame_sync_invert;
    logic       tx_clock_polarity;
    logic       network_mode_select;
    logic       rx_irq_enable;
    logic       port_enable_bit;
  } ssp_ctrl_t;

  // Control half of the control and status register.
  typedef struct packed {
    logic [11:0] rsvd;
    logic        rx_frame_sync_length;
    logic        rx_early_frame_sync;
    logic        rx_frame_sync_invert;
    logic        rx_clock_polarity;
  } ssp_csrctl_t;

  // Receive control register.
  typedef struct packed {
    logic [7:0] prescale_modulus;
    logic       rsvd;
    logic [4:0] frame_rate_divider;
    logic [1:0] word_length_field;
  } ssp_rxctl_t;

  // Link state.
  typedef enum logic [2:0] {
    SSP_OFF  = 3'b001,
    SSP_HUNT = 3'b010,
    SSP_RUN  = 3'b100
  } ssp_link_t;

endpackage : ssp_pkg

/* design/ssp_port.sv */
// Synchronous serial port: APB registers, bit/word/frame clocks, masked receive.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "ssp_regs.svh"

module ssp_port #(
  parameter int SLOTS = 32
) (
  // Clock, reset and enable.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins.
  input  wire logic        rx_bit_clock_pin_in,
  output logic             rx_bit_clock_pin_out,
  output logic             rx_bit_clock_pin_oe,
  output logic             tx_bit_clock_pin_out,
  output logic             tx_bit_clock_pin_oe,
  input  wire logic        rx_frame_sync_pin_in,
  output logic             rx_frame_sync_pin_out,
  output logic             rx_frame_sync_pin_oe,
  output logic             tx_frame_sync_pin_out,
  output logic             tx_frame_sync_pin_oe,
  input  wire logic        rx_data_pin,
  output logic             tx_data_pin_out,
  output logic             tx_data_pin_oe,
  // Receive interrupt.
  output logic             rx_irq
);

  // The slot counter is five bits wide, so the mask must cover all 32 slots.
  if (SLOTS != 32) begin : g_chk
    $error("ssp_port: SLOTS must be 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.
  // Bits per word for a word length code.
  function automatic logic [4:0] ssp_wlen(input logic [1:0] code);
    unique case (code)
      2'h0: ssp_wlen = `SSP_WL_0;
      2'h1: ssp_wlen = `SSP_WL_1;
      2'h2: ssp_wlen = `SSP_WL_2;
      2'h3: ssp_wlen = `SSP_WL_3;
    endcase
  endfunction : ssp_wlen

  // Position after {slot, bit}: the word clock wraps bits, the frame clock slots.
  function automatic logic [8:0] ssp_adv(input logic [4:0] s, input logic [3:0] b,
                                         input logic [4:0] wl, input logic [4:0] last);
    if ({1'b0, b} == wl - 5'h01) begin
      ssp_adv = {((s == last) ? 5'h00 : s + 5'h01), 4'h0};
    end else begin
      ssp_adv = {s, b + 4'h1};
    end
  endfunction : ssp_adv

  // Whether a position lies inside the frame sync pulse.
  function automatic logic ssp_in_fs(input logic [8:0] pos, input logic bitlen);
    ssp_in_fs = (pos[8:4] == 5'h00) && (!bitlen || pos[3:0] == 4'h0);
  endfunction : ssp_in_fs

  ////////////////////////////////////////////////////////////////////////////
  // Registers and APB slave.
  logic [15:0] control_reg_two, next_control_reg_two;
  logic [15:0] csr_ctl, next_csr_ctl;
  logic [15:0] rx_control_reg, next_rx_control_reg;
  logic [31:0] rx_slot_mask, next_rx_slot_mask;
  logic [15:0] tx_data_reg, next_tx_data_reg;
  logic [15:0] rx_data_reg, next_rx_data_reg;
  logic        rx_data_ready_flag, next_rx_data_ready_flag;
  logic        rx_overrun, next_rx_overrun;
  logic [31:0] next_prdata;
  logic        mapped, wr_acc, rd_rxdata;
  wire ssp_pkg::ssp_ctrl_t   ctl  = ssp_pkg::ssp_ctrl_t'(control_reg_two);
  wire ssp_pkg::ssp_csrctl_t cctl = ssp_pkg::ssp_csrctl_t'(csr_ctl);
  wire ssp_pkg::ssp_rxctl_t  rctl = ssp_pkg::ssp_rxctl_t'(rx_control_reg);

  // Word clock event from the receive datapath.
  logic word_done, slot_on;

  // Zero-wait slave: read data is captured in the setup cycle.
  assign mapped    = (paddr == `SSP_OFS_CTRL2) || (paddr == `SSP_OFS_CSR) ||
                     (paddr == `SSP_OFS_RXCTRL) || (paddr == `SSP_OFS_RXMASK) ||
                     (paddr == `SSP_OFS_RXDATA) || (paddr == `SSP_OFS_TXDATA);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;
  assign wr_acc    = psel && penable && pwrite && mapped;
  assign rd_rxdata = psel && penable && !pwrite && (paddr == `SSP_OFS_RXDATA);
  assign rx_irq    = rx_data_ready_flag && ctl.rx_irq_enable;

  // Register file next state; a new word wins over a clearing read.
  always_comb begin
    next_control_reg_two    = control_reg_two;
    next_csr_ctl            = csr_ctl;
    next_rx_control_reg     = rx_control_reg;
    next_rx_slot_mask       = rx_slot_mask;
    next_tx_data_reg        = tx_data_reg;
    next_rx_data_ready_flag = rx_data_ready_flag;
    next_rx_overrun         = rx_overrun;
    next_prdata             = prdata;
    if (wr_acc) begin
      unique case (paddr)
        `SSP_OFS_CTRL2:  next_control_reg_two = pwdata[15:0];
        `SSP_OFS_CSR:    next_csr_ctl         = pwdata[31:16];
        `SSP_OFS_RXCTRL: next_rx_control_reg  = pwdata[15:0];
        `SSP_OFS_RXMASK: next_rx_slot_mask    = pwdata;
        `SSP_OFS_TXDATA: next_tx_data_reg     = pwdata[15:0];
        default:         next_tx_data_reg     = tx_data_reg;
      endcase
    end
    if (rd_rxdata) begin
      next_rx_data_ready_flag = 1'b0;
    end
    if (word_done && slot_on) begin
      next_rx_data_ready_flag = 1'b1;
      next_rx_overrun         = rx_overrun || (rx_data_ready_flag && !rd_rxdata);
    end
    // Soft reset: status returns to its power-on state, controls stay.
    if (!ctl.port_enable_bit) begin
      next_rx_data_ready_flag = 1'b0;
      next_rx_overrun         = 1'b0;
    end
    if (psel && !penable) begin
      unique case (paddr)
        `SSP_OFS_CTRL2:  next_prdata = {16'h0000, control_reg_two};
        `SSP_OFS_CSR:    next_prdata = {csr_ctl, 14'h0000, rx_overrun, rx_data_ready_flag};
        `SSP_OFS_RXCTRL: next_prdata = {16'h0000, rx_control_reg};
        `SSP_OFS_RXMASK: next_prdata = rx_slot_mask;
        `SSP_OFS_RXDATA: next_prdata = {16'h0000, rx_data_reg};
        `SSP_OFS_TXDATA: next_prdata = {16'h0000, tx_data_reg};
        default:         next_prdata = 32'h00000000;
      endcase
    end
  end

  // Power-on reset loads every control register, clearing the enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg_two    <= `SSP_RST_CTRL;
      csr_ctl            <= `SSP_RST_CSRCTL;
      rx_control_reg     <= `SSP_RST_RXCTRL;
      rx_slot_mask       <= `SSP_RST_MASK;
      tx_data_reg        <= 16'h0000;
      rx_data_ready_flag <= 1'b0;
      rx_overrun         <= 1'b0;
      prdata             <= 32'h00000000;
    end else if (clk_en) begin
      control_reg_two    <= next_control_reg_two;
      csr_ctl            <= next_csr_ctl;
      rx_control_reg     <= next_rx_control_reg;
      rx_slot_mask       <= next_rx_slot_mask;
      tx_data_reg        <= next_tx_data_reg;
      rx_data_ready_flag <= next_rx_data_ready_flag;
      rx_overrun         <= next_rx_overrun;
      prdata             <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock, word clock, frame clock and serial datapath.
  logic [2:0]  sync1, sync2;  // {bit clock, frame sync, data}
  logic        bclk_int, next_bclk_int, bclk_d, bclk;
  logic [7:0]  div_cnt, next_div_cnt;
  logic [3:0]  bit_cnt, next_bit_cnt;
  logic [4:0]  slot_cnt, next_slot_cnt;
  logic [15:0] rx_shift_reg, next_rx_shift_reg;
  logic [15:0] tx_hold, next_tx_hold;
  logic        fs_prev, next_fs_prev;
  logic        next_tx_data_pin_out, next_tx_fs, next_rx_fs;
  logic        fs_tx, fs_rx;
  logic        cap, txe, fs_in, fs_rise, run;
  logic [4:0]  wl, last;
  logic [8:0]  pos, npos;
  logic [3:0]  tx_idx;
  ssp_pkg::ssp_link_t link, next_link;

  // Internal bit clock only while enabled, so a disabled port holds it low.
  assign bclk = ctl.clk_internal ? bclk_int : sync2[2];
  assign cap  = cctl.rx_clock_polarity ? (bclk && !bclk_d) : (!bclk && bclk_d);
  assign txe  = ctl.tx_clock_polarity ? (!bclk && bclk_d) : (bclk && !bclk_d);
  assign wl   = ssp_wlen(rctl.word_length_field);
  assign last = ctl.network_mode_select ? rctl.frame_rate_divider : 5'h00;
  assign fs_in   = sync2[1] ^ cctl.rx_frame_sync_invert;
  assign fs_rise = cap && !ctl.fs_internal && fs_in && !fs_prev;
  assign run     = (link == ssp_pkg::SSP_RUN) ||
                   (fs_rise && !cctl.rx_early_frame_sync);
  // A standard-timing sync marks the bit it arrives with as slot 0, bit 0.
  assign pos     = (fs_rise && !cctl.rx_early_frame_sync) ? 9'h000 : {slot_cnt, bit_cnt};
  assign npos    = ssp_adv(pos[8:4], pos[3:0], wl, last);
  assign slot_on = !ctl.network_mode_select || rx_slot_mask[pos[8:4]];
  assign word_done = cap && run && ({1'b0, pos[3:0]} == wl - 5'h01);
  assign tx_idx  = 4'(wl - 5'h01 - {1'b0, bit_cnt});

  // Next state of clocks, counters and shift registers.
  always_comb begin
    next_bclk_int        = bclk_int;
    next_div_cnt         = div_cnt + 8'h01;
    next_link            = link;
    next_bit_cnt         = bit_cnt;
    next_slot_cnt        = slot_cnt;
    next_rx_shift_reg    = rx_shift_reg;
    next_rx_data_reg     = rx_data_reg;
    next_tx_hold         = tx_hold;
    next_tx_data_pin_out = tx_data_pin_out;
    next_tx_fs           = fs_tx;
    next_rx_fs           = fs_rx;
    next_fs_prev         = cap ? fs_in : fs_prev;
    // Divide pclk by twice the prescale modulus plus two.
    if (div_cnt == rctl.prescale_modulus) begin
      next_div_cnt  = 8'h00;
      next_bclk_int = !bclk_int;
    end
    if (cap && run) begin
      if (slot_on) begin
        next_rx_shift_reg = {rx_shift_reg[14:0], sync2[0]};
      end
      if (word_done && slot_on) begin
        next_rx_data_reg = next_rx_shift_reg & ((16'h0001 << wl) - 16'h0001);
      end
      {next_slot_cnt, next_bit_cnt} = npos;
    end
    if (fs_rise && cctl.rx_early_frame_sync) begin
      {next_slot_cnt, next_bit_cnt} = 9'h000;
    end
    unique case (link)
      ssp_pkg::SSP_OFF:  next_link = ctl.fs_internal ? ssp_pkg::SSP_RUN : ssp_pkg::SSP_HUNT;
      ssp_pkg::SSP_HUNT: if (fs_rise) next_link = ssp_pkg::SSP_RUN;
      ssp_pkg::SSP_RUN:  next_link = ssp_pkg::SSP_RUN;
    endcase
    if (txe && link == ssp_pkg::SSP_RUN) begin
      next_tx_hold = (bit_cnt == 4'h0) ? tx_data_reg : tx_hold;
      next_tx_data_pin_out = next_tx_hold[tx_idx];
      // Early timing raises the sync one bit before the frame's first bit.
      next_tx_fs = ctl.tx_frame_sync_invert ^ ssp_in_fs(ctl.tx_early_frame_sync ?
                   ssp_adv(slot_cnt, bit_cnt, wl, last) : {slot_cnt, bit_cnt},
                   ctl.tx_frame_sync_length);
      next_rx_fs = cctl.rx_frame_sync_invert ^ ssp_in_fs(cctl.rx_early_frame_sync ?
                   ssp_adv(slot_cnt, bit_cnt, wl, last) : {slot_cnt, bit_cnt},
                   cctl.rx_frame_sync_length);
    end
    // Soft reset: counters, shifter and link return to idle, clock held low.
    if (!ctl.port_enable_bit) begin
      next_bclk_int     = 1'b0;
      next_div_cnt      = 8'h00;
      next_link         = ssp_pkg::SSP_OFF;
      next_bit_cnt      = 4'h0;
      next_slot_cnt     = 5'h00;
      next_rx_shift_reg = 16'h0000;
    end
  end

  // All state, the synchronisers too, holds while clk_en is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1           <= 3'h0;
      sync2           <= 3'h0;
      bclk_d          <= 1'b0;
      bclk_int        <= 1'b0;
      div_cnt         <= 8'h00;
      link            <= ssp_pkg::SSP_OFF;
      bit_cnt         <= 4'h0;
      slot_cnt        <= 5'h00;
      rx_shift_reg    <= 16'h0000;
      rx_data_reg     <= 16'h0000;
      tx_hold         <= 16'h0000;
      tx_data_pin_out <= 1'b0;
      fs_tx           <= 1'b0;
      fs_rx           <= 1'b0;
      fs_prev         <= 1'b0;
    end else if (clk_en) begin
      sync1           <= {rx_bit_clock_pin_in, rx_frame_sync_pin_in, rx_data_pin};
      sync2           <= sync1;
      bclk_d          <= bclk;
      bclk_int        <= next_bclk_int;
      div_cnt         <= next_div_cnt;
      link            <= next_link;
      bit_cnt         <= next_bit_cnt;
      slot_cnt        <= next_slot_cnt;
      rx_shift_reg    <= next_rx_shift_reg;
      rx_data_reg     <= next_rx_data_reg;
      tx_hold         <= next_tx_hold;
      tx_data_pin_out <= next_tx_data_pin_out;
      fs_tx           <= next_tx_fs;
      fs_rx           <= next_rx_fs;
      fs_prev         <= next_fs_prev;
    end
  end

  // Pin drivers; the receive bit clock pin is an input when external.
  assign rx_bit_clock_pin_out  = bclk_int;
  assign rx_bit_clock_pin_oe   = ctl.clk_internal;
  assign tx_bit_clock_pin_out  = bclk_int;
  assign tx_bit_clock_pin_oe   = ctl.clk_internal;
  assign tx_frame_sync_pin_out = fs_tx;
  assign tx_frame_sync_pin_oe  = ctl.fs_internal && ctl.port_enable_bit;
  assign rx_frame_sync_pin_out = fs_rx;
  assign rx_frame_sync_pin_oe  = ctl.fs_internal && ctl.port_enable_bit;
  assign tx_data_pin_oe        = (link == ssp_pkg::SSP_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_on_word: assert property (clk_en && word_done && slot_on
    && ctl.port_enable_bit |=> rx_data_ready_flag) else $error("ready flag not set");
  a_masked_no_flag: assert property (clk_en && cap && run && !slot_on && !rd_rxdata
    && ctl.port_enable_bit |=> $stable(rx_data_ready_flag) && $stable(rx_data_reg))
    else $error("masked slot changed status or data");
  a_masked_no_shift: assert property (clk_en && cap && run && !slot_on
    && ctl.port_enable_bit |=> $stable(rx_shift_reg)) else $error("masked slot sampled data");
  a_word_copy: assert property (clk_en && word_done && slot_on && ctl.port_enable_bit
    |=> rx_data_reg == ($past(next_rx_shift_reg) & ((16'h0001 << wl) - 16'h0001)))
    else $error("word not copied to receive data");
  a_read_clears: assert property (clk_en && rd_rxdata && !(word_done && slot_on)
    |=> !rx_irq) else $error("read left interrupt pending");
  a_soft_reset: assert property (clk_en && !ctl.port_enable_bit
    |=> !rx_data_ready_flag && !rx_overrun && link == ssp_pkg::SSP_OFF)
    else $error("soft reset left status set");
  a_ctrl_kept: assert property (clk_en && $fell(ctl.port_enable_bit) && !wr_acc
    |=> $stable(csr_ctl) && $stable(rx_control_reg) && $stable(rx_slot_mask))
    else $error("soft reset changed controls");
  a_clock_low: assert property (clk_en && !ctl.port_enable_bit
    |=> !bclk_int && div_cnt == 8'h00) else $error("bit clock not held low in reset");
  a_tx_edge: assert property ($changed(tx_data_pin_out) |-> $past(txe))
    else $error("transmit data changed off its edge");
  a_power_on: assert property ($rose(presetn) |-> !ctl.port_enable_bit)
    else $error("port enabled after power-on reset");

endmodule : ssp_port

/* verif/ssp_codec_model.sv */
// Behavioural model of a serial codec that drives bit clock, frame sync and data.
`timescale 1ns/10ps

module ssp_codec_model #(
  parameter int HALF = 4
) (
  // Timebase.
  input  wire logic pclk,
  // Serial link.
  output logic      bclk,
  output logic      fsync,
  output logic      sdata
);

  logic [15:0] slot_word [0:31];

  ////////////////////////////////////////////////////////////////////////////////
  // Idle link: clock low and still between frames.
  initial begin
    bclk  = 1'b0;
    fsync = 1'b0;
    sdata = 1'b0;
  end

  // Drive one frame, MSB first, bit-length sync over slot 0 bit 0.
  // Data changes with the rising bit clock so it is stable at the falling capture edge.
  task automatic send_frame(input int wl, input int nslots);
    for (int s = 0; s < nslots; s++) begin
      for (int b = wl - 1; b >= 0; b--) begin
        @(posedge pclk);
        bclk  <= 1'b1;
        fsync <= (s == 0) && (b == wl - 1);
        sdata <= slot_word[s][b];
        repeat (HALF) @(posedge pclk);
        bclk <= 1'b0;
        repeat (HALF - 1) @(posedge pclk);
      end
    end
    @(posedge pclk);
    fsync <= 1'b0;
    // Released line shows the inverse so a late sample is never lucky.
    sdata <= ~sdata;
  endtask : send_frame

endmodule : ssp_codec_model

/* verif/serial_port_rx_slot_mask_reset_clocks_tb.sv */
// Self-checking bench for the serial port receive, reset and register behaviour.
`timescale 1ns/10ps
`include "ssp_regs.svh"

module serial_port_rx_slot_mask_reset_clocks_tb;

  localparam int          NS [4] = '{5, 3, 4, 2};
  localparam logic [31:0] MK [4] = '{32'h5, 32'hffffffff, 32'h6, 32'hffffffff};
  localparam logic [31:0] CSRV   = 32'h00080000;

  logic        pclk;
  logic        presetn;
  logic        clk_en;
  logic        bclk_out;
  logic        bclk_oe;
  time         t0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_irq;
  logic        bclk;
  logic        fsync;
  logic        sdata;
  logic [31:0] expq [$];
  int          miscompares;
  int          num_checks;
  int          cycles;

  ssp_port uut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_bit_clock_pin_in(bclk), .rx_bit_clock_pin_out(bclk_out), .rx_bit_clock_pin_oe(bclk_oe),
    .tx_bit_clock_pin_out(), .tx_bit_clock_pin_oe(),
    .rx_frame_sync_pin_in(fsync), .rx_frame_sync_pin_out(), .rx_frame_sync_pin_oe(),
    .tx_frame_sync_pin_out(), .tx_frame_sync_pin_oe(),
    .rx_data_pin(sdata), .tx_data_pin_out(), .tx_data_pin_oe(), .rx_irq(rx_irq)
  );

  ssp_codec_model #(.HALF(4)) codec (.pclk(pclk), .bclk(bclk), .fsync(fsync), .sdata(sdata));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and cycle ceiling; a hang is counted as a mismatch.
  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer: setup, then access held until pready; only the ceiling ends a wait.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    expq.push_back(exp);
    apb(1'b0, addr, 32'h0);
  endtask : rd

  // Bounded wait for the receive interrupt.
  task automatic wait_irq();
    int n;
    n = 0;
    while (rx_irq !== 1'b1 && n < 4000) begin
      n++;
      @(posedge pclk);
    end
    if (n == 4000) check("rx_irq wait", 32'h0, 32'h1);
  endtask : wait_irq

  // Send one frame; with interrupts on, read each enabled slot as it lands.
  task automatic frame(input int code, input int ns, input logic [31:0] mask, input bit irq);
    int wl;
    wl = (code == 3) ? 16 : 8 + 2 * code;
    for (int s = 0; s < ns; s++) codec.slot_word[s] = 16'($urandom);
    fork
      codec.send_frame(wl, ns);
      if (irq) for (int s = 0; s < ns; s++) if (mask[s]) begin
        wait_irq();
        rd(`SSP_OFS_RXDATA, 32'(codec.slot_word[s]) & ((32'h1 << wl) - 1));
        @(negedge pclk);
        check("rx_irq", {31'h0, rx_irq}, 32'h0);
      end
    join
  endtask : frame

  ////////////////////////////////////////////////////////////////////////////////
  // Compare each completed read with the oldest note, and the error flag.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      check("pslverr", {31'h0, pslverr}, {31'h0, paddr > `SSP_OFS_TXDATA});
      if (!pwrite && expq.size() == 0) check("read queue", 32'h1, 32'h0);
      else if (!pwrite) check("prdata", prdata, expq.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    ssp_pkg::ssp_rxctl_t rxc;
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(31));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SSP_OFS_CTRL2, 32'h0);
    rd(`SSP_OFS_CSR, 32'h0);
    rd(`SSP_OFS_RXCTRL, 32'h0);
    rd(`SSP_OFS_RXMASK, `SSP_RST_MASK);
    rd(8'h40, 32'h0);
    check("bit clock enable", {31'h0, bclk_oe}, 32'h0);
    $display("reset values test done");
    // Every word length, masked and unmasked network frames.
    for (int c = 0; c < 4; c++) begin
      rxc = '{prescale_modulus: 8'h00, rsvd: 1'b0,
              frame_rate_divider: 5'(NS[c] - 1), word_length_field: 2'(c)};
      apb(1'b1, `SSP_OFS_CTRL2, 32'h0);
      repeat (8) @(posedge pclk);
      apb(1'b1, `SSP_OFS_CSR, CSRV);
      apb(1'b1, `SSP_OFS_RXCTRL, {16'h0, rxc});
      apb(1'b1, `SSP_OFS_RXMASK, MK[c]);
      apb(1'b1, `SSP_OFS_CTRL2, 32'h7);
      frame(c, NS[c], MK[c], 1'b1);
      rd(`SSP_OFS_CSR, CSRV);
      $display("frame test done, word length code %0d", c);
    end
    // Ready flag without interrupt enable, then a soft reset.
    apb(1'b1, `SSP_OFS_CTRL2, 32'h4);
    repeat (8) @(posedge pclk);
    apb(1'b1, `SSP_OFS_CTRL2, 32'h5);
    frame(3, 1, 32'h1, 1'b0);
    repeat (20) @(posedge pclk);
    check("rx_irq", {31'h0, rx_irq}, 32'h0);
    rd(`SSP_OFS_CSR, CSRV | 32'h1);
    // A frozen port must ignore this write, so the flag survives it.
    clk_en <= 1'b0;
    apb(1'b1, `SSP_OFS_CTRL2, 32'h4);
    clk_en <= 1'b1;
    rd(`SSP_OFS_CSR, CSRV | 32'h1);
    apb(1'b1, `SSP_OFS_CTRL2, 32'h4);
    rd(`SSP_OFS_CSR, CSRV);
    rd(`SSP_OFS_CTRL2, 32'h4);
    rd(`SSP_OFS_RXMASK, MK[3]);
    rd(`SSP_OFS_RXCTRL, {16'h0, rxc});
    $display("soft reset test done");
    // Internal bit clock: modulus 2 gives six pclk periods per bit on the pin.
    apb(1'b1, `SSP_OFS_RXCTRL, 32'h0200);
    apb(1'b1, `SSP_OFS_CTRL2, 32'h81);
    @(posedge bclk_out);
    t0 = $time;
    @(posedge bclk_out);
    check("bit clock period", 32'($time - t0), 32'h78);
    check("bit clock enable", {31'h0, bclk_oe}, 32'h1);
    $display("internal clock test done");
    repeat (4) @(posedge pclk);
    results();
  end

endmodule : serial_port_rx_slot_mask_reset_clocks_tb
